// ### include/acltb_defines.svh
`ifndef ACLTB_DEFINES_SVH
`define ACLTB_DEFINES_SVH

// register indices; the byte address is four times the index
`define ACLTB_IDX_HOLD_BASE 14'h0600
`define ACLTB_IDX_ACCESS_B 14'h060b
`define ACLTB_IDX_ACCESS_C 14'h060c
`define ACLTB_IDX_ACCESS_D 14'h060d
`define ACLTB_IDX_ACCESS_E 14'h060e
`define ACLTB_IDX_ACCESS_F 14'h060f
`define ACLTB_IDX_BE_HIGH 14'h0610
`define ACLTB_IDX_BE_LOW 14'h0611
`define ACLTB_IDX_CTRL 14'h0612

// holding byte lanes
`define ACLTB_LANE_FIRST_RULE 4'h0
`define ACLTB_LANE_MODE 4'h1
`define ACLTB_LANE_A 4'ha
`define ACLTB_LANE_B 4'hb
`define ACLTB_LANE_D 4'hd
`define ACLTB_LANE_E 4'he
`define ACLTB_LANE_F 4'hf

// field positions
`define ACLTB_FIRST_RULE_MASK 8'h0f
`define ACLTB_MODE_MSB 5
`define ACLTB_MODE_LSB 4
`define ACLTB_REMARK_EN_BIT 2
`define ACLTB_REMARK_HI_MSB 1
`define ACLTB_REMARK_HI_LSB 0
`define ACLTB_REMARK_LSB_BIT 7
`define ACLTB_MAP_MODE_MSB 6
`define ACLTB_MAP_MODE_LSB 5
`define ACLTB_FWD_MSB 6
`define ACLTB_CTRL_WDONE 6
`define ACLTB_CTRL_RDONE 5
`define ACLTB_CTRL_DIR 4
`define ACLTB_CTRL_IDX_MSB 3

// reset values
`define ACLTB_HOLD_RST 8'h00
`define ACLTB_BE_RST 8'h00
`define ACLTB_CTRL_RW_RST 5'h00
`define ACLTB_DONE_RST 1'b1

// timing and bus answers
`define ACLTB_XFER_CYCLES 2'd2
`define ACLTB_RESP_OKAY 2'b00
`define ACLTB_RESP_SLVERR 2'b10

`endif

// ### include/acltb_pkg.sv
package acltb_pkg;

  typedef enum logic [1:0] {
    acltb_st_idle = 2'b00,
    acltb_st_busy = 2'b01,
    acltb_st_finish = 2'b10
  } acltb_state_t;

  typedef enum logic [1:0] {
    acltb_mode_none = 2'b00,
    acltb_mode_l2_header = 2'b01,
    acltb_mode_l3_address = 2'b10,
    acltb_mode_l4_port = 2'b11
  } acltb_mode_t;

  typedef logic [15:0][7:0] acltb_bytes_t;

  typedef struct packed {
    logic write;
    logic [3:0] index;
    logic [15:0] sel;
  } acltb_xfer_t;

  typedef struct packed {
    logic [3:0] first_rule_number;
    acltb_mode_t filter_mode;
    logic remark_priority_enable;
    logic [2:0] remark_prio;
    logic [1:0] map_mode_sel;
    logic [6:0] fwd_map;
    logic [15:0] ruleset;
  } acltb_rule_t;

endpackage : acltb_pkg

// ### hdl/acltb_flag.sv
`timescale 1ns/1ps
`include "acltb_defines.svh"

module acltb_flag (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // events
  input wire logic clr,
  input wire logic set,
  // flag
  output logic q
);

  logic q_q;

  // set wins so a completion is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= `ACLTB_DONE_RST;
    end else if (set) begin
      q_q <= 1'b1;
    end else if (clr) begin
      q_q <= 1'b0;
    end
  end

  assign q = q_q;

endmodule : acltb_flag

// ### hdl/acltb_lane.sv
`timescale 1ns/1ps
`include "acltb_defines.svh"

module acltb_lane (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // transfer port
  input wire logic we,
  input wire logic [3:0] widx,
  input wire logic [7:0] wdata,
  input wire logic [3:0] ridx_a,
  output logic [7:0] rdata_a,
  // lookup port
  input wire logic [3:0] ridx_b,
  output logic [7:0] rdata_b
);

  logic [15:0][7:0] mem_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_q <= {16{`ACLTB_HOLD_RST}};
    end else if (we) begin
      mem_q[widx] <= wdata;
    end
  end

  assign rdata_a = mem_q[ridx_a];
  assign rdata_b = mem_q[ridx_b];

endmodule : acltb_lane

// ### hdl/acltb_top.sv
`timescale 1ns/1ps
`include "acltb_defines.svh"

module acltb_top
  import acltb_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // rule lookup for the forwarding logic
  input wire logic [3:0] lookup_index,
  output acltb_rule_t lookup_rule,
  output logic xfer_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  acltb_state_t st_q;
  acltb_state_t st_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  acltb_xfer_t xfer_q;
  acltb_xfer_t xfer_d;
  acltb_bytes_t hold_q;
  acltb_bytes_t hold_d;
  acltb_bytes_t xfer_rdata;
  acltb_bytes_t look_rdata;
  acltb_bytes_t sel_mask;
  logic [7:0] be_high_q;
  logic [7:0] be_low_q;
  logic [4:0] ctrl_q;
  logic wdone;
  logic rdone;
  acltb_rule_t lookup_rule_q;
  acltb_rule_t rule_d;

  logic have_aw_q;
  logic [15:0] aw_addr_q;
  logic have_w_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_byte;
  logic rd_ok;

  wire logic [13:0] hold_base = `ACLTB_IDX_HOLD_BASE;

  //////////////////////////////////////////////////////////////////////////////
  // write channel decode

  wire logic do_write = have_aw_q && have_w_q && !bvalid_q;
  wire logic [13:0] wr_idx = aw_addr_q[15:2];
  wire logic [3:0] wr_lane = wr_idx[3:0];
  wire logic wr_hold = (wr_idx[13:4] == hold_base[13:4]);
  wire logic wr_be_high = (wr_idx == `ACLTB_IDX_BE_HIGH);
  wire logic wr_be_low = (wr_idx == `ACLTB_IDX_BE_LOW);
  wire logic wr_ctrl = (wr_idx == `ACLTB_IDX_CTRL);
  wire logic wr_mapped = wr_hold || wr_be_high || wr_be_low || wr_ctrl;
  // only byte lane 0 carries register data
  wire logic wr_en = do_write && w_strb_q && wr_mapped;
  wire logic start_req = wr_en && wr_be_low;
  // a start while a transfer runs stores the select but is not acted on
  wire logic start_ok = start_req && (st_q == acltb_st_idle);
  wire logic start_wr = start_ok && ctrl_q[`ACLTB_CTRL_DIR];
  wire logic start_rd = start_ok && !ctrl_q[`ACLTB_CTRL_DIR];
  wire logic finish_wr = (st_q == acltb_st_finish) && xfer_q.write;
  wire logic finish_rd = (st_q == acltb_st_finish) && !xfer_q.write;

  // the low half of the select is the byte being written right now
  wire logic [15:0] be_word = {be_high_q, w_data_q};
  wire logic [15:0] be_sel = {<<{be_word}};
  wire logic [15:0] lane_we = finish_wr ? xfer_q.sel : 16'h0000;

  assign awready = !have_aw_q && !bvalid_q;
  assign wready = !have_w_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign xfer_busy = (st_q != acltb_st_idle);
  assign lookup_rule = lookup_rule_q;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_q <= 1'b0;
      aw_addr_q <= 16'h0000;
      have_w_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ACLTB_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        have_aw_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        have_aw_q <= 1'b0;
      end
      if (wvalid && wready) begin
        have_w_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_strb_q <= wstrb[0];
      end else if (do_write) begin
        have_w_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `ACLTB_RESP_OKAY : `ACLTB_RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  wire logic [13:0] rd_idx = araddr[15:2];

  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (rd_idx[13:4] == hold_base[13:4]) begin
      rd_byte = hold_q[rd_idx[3:0]];
    end else if (rd_idx == `ACLTB_IDX_BE_HIGH) begin
      rd_byte = be_high_q;
    end else if (rd_idx == `ACLTB_IDX_BE_LOW) begin
      rd_byte = be_low_q;
    end else if (rd_idx == `ACLTB_IDX_CTRL) begin
      rd_byte = {1'b0, wdone, rdone, ctrl_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `ACLTB_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_ok ? `ACLTB_RESP_OKAY : `ACLTB_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      be_high_q <= `ACLTB_BE_RST;
      be_low_q <= `ACLTB_BE_RST;
      ctrl_q <= `ACLTB_CTRL_RW_RST;
      hold_q <= {16{`ACLTB_HOLD_RST}};
    end else begin
      if (wr_en && wr_be_high) begin
        be_high_q <= w_data_q;
      end
      if (wr_en && wr_be_low) begin
        be_low_q <= w_data_q;
      end
      if (wr_en && wr_ctrl) begin
        ctrl_q <= w_data_q[4:0];
      end
      hold_q <= hold_d;
    end
  end

  // table results override a bus write landing in the same cycle
  always_comb begin
    hold_d = hold_q;
    if (wr_en && wr_hold) begin
      if (wr_lane == `ACLTB_LANE_FIRST_RULE) begin
        hold_d[wr_lane] = w_data_q & `ACLTB_FIRST_RULE_MASK;
      end else begin
        hold_d[wr_lane] = w_data_q;
      end
    end
    for (int k = 0; k < 16; k++) begin
      if (finish_rd && xfer_q.sel[k]) begin
        hold_d[k] = xfer_rdata[k];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    xfer_d = xfer_q;
    case (st_q)
      acltb_st_idle: begin
        if (start_ok) begin
          st_d = acltb_st_busy;
          cnt_d = `ACLTB_XFER_CYCLES - 2'd1;
          xfer_d.write = ctrl_q[`ACLTB_CTRL_DIR];
          xfer_d.index = ctrl_q[`ACLTB_CTRL_IDX_MSB:0];
          xfer_d.sel = be_sel;
        end
      end
      acltb_st_busy: begin
        if (cnt_q == 2'd0) begin
          st_d = acltb_st_finish;
        end else begin
          cnt_d = cnt_q - 2'd1;
        end
      end
      acltb_st_finish: begin
        st_d = acltb_st_idle;
      end
      default: begin
        st_d = acltb_st_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= acltb_st_idle;
      cnt_q <= 2'd0;
      xfer_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      xfer_q <= xfer_d;
    end
  end

  acltb_flag u_wdone (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(start_wr),
    .set(finish_wr),
    .q(wdone)
  );

  acltb_flag u_rdone (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(start_rd),
    .set(finish_rd),
    .q(rdone)
  );

  //////////////////////////////////////////////////////////////////////////////
  // this port's private rule table, one lane per holding byte

  for (genvar k = 0; k < 16; k++) begin : g_lane
    assign sel_mask[k] = {8{xfer_q.sel[k]}};
    acltb_lane u_lane (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(lane_we[k]),
      .widx(xfer_q.index),
      .wdata(hold_q[k]),
      .ridx_a(xfer_q.index),
      .rdata_a(xfer_rdata[k]),
      .ridx_b(lookup_index),
      .rdata_b(look_rdata[k])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // rule lookup decode

  assign rule_d.first_rule_number = look_rdata[`ACLTB_LANE_FIRST_RULE][3:0];
  assign rule_d.filter_mode =
    acltb_mode_t'(look_rdata[`ACLTB_LANE_MODE][`ACLTB_MODE_MSB:`ACLTB_MODE_LSB]);
  assign rule_d.remark_priority_enable = look_rdata[`ACLTB_LANE_A][`ACLTB_REMARK_EN_BIT];
  assign rule_d.remark_prio = {
    look_rdata[`ACLTB_LANE_A][`ACLTB_REMARK_HI_MSB:`ACLTB_REMARK_HI_LSB],
    look_rdata[`ACLTB_LANE_B][`ACLTB_REMARK_LSB_BIT]
  };
  assign rule_d.map_mode_sel =
    look_rdata[`ACLTB_LANE_B][`ACLTB_MAP_MODE_MSB:`ACLTB_MAP_MODE_LSB];
  assign rule_d.fwd_map = look_rdata[`ACLTB_LANE_D][`ACLTB_FWD_MSB:0];
  assign rule_d.ruleset = {look_rdata[`ACLTB_LANE_E], look_rdata[`ACLTB_LANE_F]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lookup_rule_q <= '0;
    end else begin
      lookup_rule_q <= rule_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  chk_wr_done_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    start_wr |=> !wdone [*3] ##1 wdone)
    else $error("write done flag timing wrong");

  chk_rd_done_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    start_rd |=> !rdone [*3] ##1 rdone)
    else $error("read done flag timing wrong");

  chk_start_by_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == acltb_st_idle && !start_ok) |=> st_q == acltb_st_idle)
    else $error("transfer started without low select write");

  chk_busy_ignores_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_req && st_q != acltb_st_idle) |=> $stable(xfer_q))
    else $error("start taken while busy");

  chk_high_sel_order: assert property (@(posedge aclk) disable iff (!aresetn)
    start_ok |=> xfer_q.sel[7] == $past(be_high_q[0]) && xfer_q.sel[0] == $past(be_high_q[7]))
    else $error("high select mapped wrong");

  chk_low_sel_order: assert property (@(posedge aclk) disable iff (!aresetn)
    start_ok |=> xfer_q.sel[15] == $past(w_data_q[0]) && xfer_q.sel[8] == $past(w_data_q[7]))
    else $error("low select mapped wrong");

  chk_index_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    start_ok |=> xfer_q.index == $past(ctrl_q[3:0]))
    else $error("entry index not taken from control");

  chk_read_loads_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    finish_rd |=> ((hold_q ^ $past(xfer_rdata)) & $past(sel_mask)) == '0)
    else $error("selected bytes not loaded by read");

  chk_write_stores_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    finish_wr |=> ((xfer_rdata ^ $past(hold_q)) & $past(sel_mask)) == '0)
    else $error("selected bytes not stored by write");

  chk_remark_low_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> lookup_rule_q.remark_prio[0] == $past(look_rdata[`ACLTB_LANE_B][7]))
    else $error("remark priority low bit wrong");

  chk_remark_high_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> lookup_rule_q.remark_prio[2:1] == $past(look_rdata[`ACLTB_LANE_A][1:0]))
    else $error("remark priority high bits wrong");

  chk_fwd_map_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> lookup_rule_q.fwd_map == $past(look_rdata[`ACLTB_LANE_D][6:0]))
    else $error("forward map wrong");

  chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_q && !bready) |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped before taken");

  chk_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && !rd_ok) |=> rresp_q == `ACLTB_RESP_SLVERR && rdata_q == '0)
    else $error("unmapped read not answered with error");

endmodule : acltb_top

// ### verif/acltb_top_tb_top.sv
`timescale 1ns/1ps
`include "acltb_defines.svh"

module acltb_top_tb_top
  import acltb_pkg::*;
;
  typedef struct packed {
    logic use_it;
    logic [1:0] resp;
    logic [31:0] data;
  } acltb_note_t;

  logic aclk, aresetn;
  logic [15:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, lookup_index;
  logic [1:0] bresp, rresp;
  logic arvalid, arready, rvalid, rready, xfer_busy;
  acltb_rule_t lookup_rule;
  acltb_note_t exp_r[$];
  logic [1:0] exp_b[$];
  logic [7:0] hold [16];
  logic [7:0] tbl [16][16];
  int fails = 0;
  int num_checks = 0;

  acltb_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lookup_index(lookup_index), .lookup_rule(lookup_rule), .xfer_busy(xfer_busy)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a wait that runs out ends the run at once
  task automatic bound(input int n);
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
  endtask : bound

  function automatic logic mapped(input logic [13:0] i);
    return i >= `ACLTB_IDX_HOLD_BASE && i <= `ACLTB_IDX_CTRL;
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [13:0] i, input logic [7:0] d, input logic [3:0] s);
    logic awt, wt;
    int n;
    awt = 1'b0;
    wt = 1'b0;
    n = 0;
    exp_b.push_back(mapped(i) ? `ACLTB_RESP_OKAY : `ACLTB_RESP_SLVERR);
    awaddr <= {i, 2'b00};
    wdata <= {24'($urandom()), d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awt && wt) && n < 50) begin
      @(posedge aclk);
      n++;
      if (!awt && awready) begin
        awt = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wt && wready) begin
        wt = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bound(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 50);
    bound(n);
  endtask : wr

  task automatic rd(input logic [13:0] i, input logic chk, input logic [7:0] e,
                    output logic [7:0] got);
    int n;
    n = 0;
    exp_r.push_back({chk, mapped(i) ? `ACLTB_RESP_OKAY : `ACLTB_RESP_SLVERR,
                     mapped(i) ? {24'h000000, e} : 32'h00000000});
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 50);
    bound(n);
    got = rdata[7:0];
  endtask : rd

  task automatic wr_hold(input int k, input logic [7:0] d);
    // byte 0 keeps only its low nibble
    hold[k] = (k == 0) ? (d & `ACLTB_FIRST_RULE_MASK) : d;
    wr(`ACLTB_IDX_HOLD_BASE + 14'(k), d, 4'h1);
  endtask : wr_hold

  task automatic xfer(input logic dir, input logic [3:0] idx, input logic [15:0] sel);
    logic [7:0] g;
    int n;
    n = 0;
    wr(`ACLTB_IDX_CTRL, {3'b000, dir, idx}, 4'h1);
    wr(`ACLTB_IDX_BE_HIGH, sel[15:8], 4'h1);
    wr(`ACLTB_IDX_BE_LOW, sel[7:0], 4'h1);
    // read at the edge, before the design updates
    check(xfer_busy, 1'b1);
    rd(`ACLTB_IDX_CTRL, 1'b1, {1'b0, !dir, dir, dir, idx}, g);
    do begin
      rd(`ACLTB_IDX_CTRL, 1'b0, 8'h00, g);
      n++;
    end while (!(g[6] && g[5]) && n < 50);
    bound(n);
    rd(`ACLTB_IDX_CTRL, 1'b1, {3'b011, dir, idx}, g);
    for (int k = 0; k < 16; k++) begin
      if (sel[15 - k]) begin
        if (dir) tbl[idx][k] = hold[k];
        else hold[k] = tbl[idx][k];
      end
    end
  endtask : xfer

  task automatic chk_lookup(input logic [3:0] i);
    acltb_rule_t e;
    lookup_index <= i;
    repeat (2) @(posedge aclk);
    e.first_rule_number = tbl[i][0][3:0];
    e.filter_mode = acltb_mode_t'(tbl[i][1][5:4]);
    e.remark_priority_enable = tbl[i][10][2];
    e.remark_prio = {tbl[i][10][1:0], tbl[i][11][7]};
    e.map_mode_sel = tbl[i][11][6:5];
    e.fwd_map = tbl[i][13][6:0];
    e.ruleset = {tbl[i][14], tbl[i][15]};
    check(64'(lookup_rule), 64'(e));
  endtask : chk_lookup

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: each answer takes the oldest note
  always @(posedge aclk) begin
    acltb_note_t nt;
    if (bvalid && bready) begin
      if (exp_b.size() == 0) fails++;
      else check(bresp, exp_b.pop_front());
    end
    if (rvalid && rready) begin
      if (exp_r.size() == 0) begin
        fails++;
      end else begin
        nt = exp_r.pop_front();
        if (nt.use_it) begin
          check(rdata, nt.data);
          check(rresp, nt.resp);
        end
      end
    end
  end

  initial begin
    logic [7:0] g;
    logic [3:0] ix [4];
    logic [15:0] sel;
    aresetn = 1'b0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    lookup_index = 4'h0;
    // readiness held high, so every answer is taken at once
    bready = 1'b1;
    rready = 1'b1;
    for (int a = 0; a < 16; a++) begin
      hold[a] = 8'h00;
      for (int b = 0; b < 16; b++) tbl[a][b] = 8'h00;
    end
    void'($urandom(32'hb7951a8c));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ACLTB_IDX_CTRL, 1'b1, 8'h60, g);
    for (int k = 11; k < 18; k++) rd(`ACLTB_IDX_HOLD_BASE + 14'(k), 1'b1, 8'h00, g);
    rd(14'h0613, 1'b1, 8'h00, g);
    wr(14'h0613, 8'h5a, 4'h1);
    for (int k = 0; k < 16; k++) wr_hold(k, 8'($urandom()));
    wr(`ACLTB_IDX_HOLD_BASE + 14'd5, ~hold[5], 4'he);
    for (int k = 0; k < 16; k++) rd(`ACLTB_IDX_HOLD_BASE + 14'(k), 1'b1, hold[k], g);
    // one full write per filter mode, each to its own entry
    for (int m = 0; m < 4; m++) begin
      ix[m] = 4'(4 * m) + 4'($urandom_range(3));
      for (int k = 0; k < 16; k++) wr_hold(k, 8'($urandom()));
      wr_hold(1, {hold[1][7:6], 2'(m), hold[1][3:0]});
      xfer(1'b1, ix[m], 16'hffff);
      chk_lookup(ix[m]);
    end
    for (int m = 0; m < 4; m++) chk_lookup(ix[m]);
    // partial write over an entry already filled
    for (int k = 0; k < 16; k++) wr_hold(k, 8'($urandom()));
    xfer(1'b1, ix[2], 16'($urandom()));
    chk_lookup(ix[2]);
    // reads touch only the selected holding bytes
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 16; k++) wr_hold(k, 8'($urandom()));
      sel = (r == 0) ? 16'h8001 : 16'($urandom());
      xfer(1'b0, ix[r + 1], sel);
      for (int k = 0; k < 16; k++) rd(`ACLTB_IDX_HOLD_BASE + 14'(k), 1'b1, hold[k], g);
    end
    // a second start lands while the first is finishing: stored, not launched
    wr(`ACLTB_IDX_CTRL, {4'h1, ix[3]}, 4'h1);
    wr(`ACLTB_IDX_BE_HIGH, 8'hff, 4'h1);
    wr(`ACLTB_IDX_BE_LOW, 8'hff, 4'h1);
    wr(`ACLTB_IDX_BE_LOW, 8'h00, 4'h1);
    check(xfer_busy, 1'b0);
    rd(`ACLTB_IDX_BE_LOW, 1'b1, 8'h00, g);
    rd(`ACLTB_IDX_CTRL, 1'b1, {4'h7, ix[3]}, g);
    for (int k = 0; k < 16; k++) tbl[ix[3]][k] = hold[k];
    chk_lookup(ix[3]);
    chk_lookup(ix[0]);
    report_and_stop();
  end
endmodule : acltb_top_tb_top
